// file: rtl/xpc_pkg.sv
/*
  xpc_pkg: constants and carrier types for the crosspoint route programming controller.
  Assumes a 10 MHz system clock; pin timing figures are converted to whole cycles here.
*/
package xpc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // pin timing figures in ns
  localparam int T_STEP_NS = 15;   // vector period / least strobe width
  localparam int T_RESET_NS = 15;  // least reset pulse width
  localparam int T_DIS_NS = 30;    // worst output disable time after reset
  localparam int T_ACC_NS = 30;    // worst readback access / release time
  // cycle counts: least times round up, never below one cycle
  localparam int STEP_CYC = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIS_CYC = (T_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // field layout of the route word
  localparam int IDX_W = 5;
  localparam int WORD_W = 7;
  localparam int EN_POS = 6;
  localparam int NUM_OUT = 17;
  localparam int NUM_IN = 33;
  localparam logic [IDX_W-1:0] BCAST_IDX = 5'h11;
  localparam logic [IDX_W-1:0] MAX_IDX = 5'h10;
  localparam logic [5:0] MAX_IN = 6'h20;
  // host commands
  typedef enum logic [2:0] {
    XPC_CMD_WRITE, XPC_CMD_UPDATE, XPC_CMD_READ, XPC_CMD_RESET, XPC_CMD_XWRITE
  } xpc_cmd_t;
  // one request from the user side
  typedef struct packed {
    xpc_cmd_t cmd;
    logic [IDX_W-1:0] index;
    logic [WORD_W-1:0] word;
  } xpc_req_t;
  // pin levels driven toward the switch
  typedef struct packed {
    logic select_n;
    logic write_n;
    logic read_n;
    logic update_n;
    logic reset_n;
    logic [IDX_W-1:0] index;
  } xpc_pins_t;
endpackage

// file: rtl/xpc_strobe_timer.sv
/*
  xpc_strobe_timer: counts a loaded number of cycles and flags when it has run out.
  Assumes a single clock domain and a load pulse from the owning state machine.
*/
`timescale 1ns/1ps
`default_nettype none
module xpc_strobe_timer #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] count,
  // status
  output logic done
);
  logic [W-1:0] cnt_q;

  // down counter; done is high whenever it sits at zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // done looks at the count only: the owner reloads from done, so a load term here would loop
  assign done = (cnt_q == '0);
endmodule
`default_nettype wire

// file: rtl/xpc_host.sv
/*
  xpc_host: controller that programs a 33x17 crosspoint through its parallel control pins.
  Assumes the switch latches are level sensitive and that the data pins are resolved by the
  surrounding wiring from data_out/data_oe_n; data_in arrives asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module xpc_host (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // user request side
  input wire logic req_valid,
  input wire xpc_pkg::xpc_req_t req,
  output logic req_ready,
  output logic req_reject,
  output logic rd_valid,
  output logic [xpc_pkg::WORD_W-1:0] rd_word,
  // switch control pins
  output var xpc_pkg::xpc_pins_t pins,
  // switch data pins, three signals for the two-way bus
  input wire logic [xpc_pkg::WORD_W-1:0] data_in,
  output logic [xpc_pkg::WORD_W-1:0] data_out,
  output logic data_oe_n
);
  typedef enum logic [2:0] {
    XPC_IDLE, XPC_SETUP, XPC_PULSE, XPC_HOLD, XPC_READ, XPC_DONE
  } xpc_state_t;

  xpc_state_t state_q;
  xpc_pkg::xpc_req_t cur_q;
  xpc_pkg::xpc_pins_t pins_q;
  logic [xpc_pkg::WORD_W-1:0] dout_q;
  logic oe_n_q;
  logic ready_q;
  logic reject_q;
  logic rd_valid_q;
  logic [xpc_pkg::WORD_W-1:0] rd_word_q;
  logic [xpc_pkg::WORD_W-1:0] din_meta_q;
  logic [xpc_pkg::WORD_W-1:0] din_sync_q;
  logic tmr_load;
  logic [xpc_pkg::CNT_W-1:0] tmr_count;
  logic tmr_done;

  // reserved index or input numbers are refused before any pin moves
  function automatic logic xpc_legal(input xpc_pkg::xpc_req_t r);
    logic ok;
    ok = 1'b1;
    if (r.cmd == xpc_pkg::XPC_CMD_WRITE || r.cmd == xpc_pkg::XPC_CMD_XWRITE) begin
      if (r.index > xpc_pkg::BCAST_IDX) begin
        ok = 1'b0;
      end else if (r.word[xpc_pkg::EN_POS] && (r.word[5:0] > xpc_pkg::MAX_IN)) begin
        ok = 1'b0;
      end
    end else if (r.cmd == xpc_pkg::XPC_CMD_READ) begin
      if (r.index > xpc_pkg::MAX_IDX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // strobe width, setup and access counts in cycles
  function automatic logic [xpc_pkg::CNT_W-1:0] xpc_width(input xpc_pkg::xpc_cmd_t c);
    logic [xpc_pkg::CNT_W-1:0] n;
    n = xpc_pkg::CNT_W'(xpc_pkg::STEP_CYC);
    if (c == xpc_pkg::XPC_CMD_RESET) begin
      n = xpc_pkg::CNT_W'(xpc_pkg::DIS_CYC);
    end else if (c == xpc_pkg::XPC_CMD_READ) begin
      n = xpc_pkg::CNT_W'(xpc_pkg::ACC_CYC);
    end
    return n;
  endfunction

  xpc_strobe_timer #(
    .W(xpc_pkg::CNT_W)
  ) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // timer restarts on acceptance and on leaving each timed phase (setup, pulse, read)
  assign tmr_load = (state_q == XPC_IDLE && req_valid && ready_q && xpc_legal(req))
    || ((state_q == XPC_SETUP || state_q == XPC_PULSE || state_q == XPC_READ) && tmr_done);
  assign tmr_count = (state_q == XPC_IDLE) ? xpc_pkg::CNT_W'(xpc_pkg::STEP_CYC)
    : xpc_width(cur_q.cmd);

  // data pins are asynchronous: two flops before anything reads them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
    end else begin
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // sequencing of one pin transaction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= XPC_IDLE;
      cur_q <= '0;
    end else begin
      case (state_q)
        XPC_IDLE: begin
          if (req_valid && ready_q && xpc_legal(req)) begin
            cur_q <= req;
            state_q <= XPC_SETUP;
          end
        end
        XPC_SETUP: begin
          if (tmr_done) begin
            state_q <= XPC_PULSE;
          end
        end
        XPC_PULSE: begin
          if (tmr_done) begin
            state_q <= (cur_q.cmd == xpc_pkg::XPC_CMD_READ) ? XPC_READ : XPC_HOLD;
          end
        end
        XPC_READ: begin
          if (tmr_done) begin
            state_q <= XPC_HOLD;
          end
        end
        XPC_HOLD: begin
          state_q <= XPC_DONE;
        end
        default: begin
          state_q <= XPC_IDLE;
        end
      endcase
    end
  end

  // pin levels; every strobe idles high and select frames all work except reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_q <= '{select_n: 1'b1, write_n: 1'b1, read_n: 1'b1, update_n: 1'b1,
        reset_n: 1'b1, index: '0};
      dout_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        XPC_IDLE: begin
          pins_q.select_n <= 1'b1;
          pins_q.write_n <= 1'b1;
          pins_q.read_n <= 1'b1;
          pins_q.update_n <= 1'b1;
          pins_q.reset_n <= 1'b1;
          oe_n_q <= 1'b1;
        end
        XPC_SETUP: begin
          // reset is issued with select high; all else under select low
          pins_q.select_n <= (cur_q.cmd == xpc_pkg::XPC_CMD_RESET);
          pins_q.index <= cur_q.index;
          dout_q <= cur_q.word;
          oe_n_q <= (cur_q.cmd == xpc_pkg::XPC_CMD_READ
            || cur_q.cmd == xpc_pkg::XPC_CMD_UPDATE
            || cur_q.cmd == xpc_pkg::XPC_CMD_RESET);
          // transparent write holds update low across the write pulse
          pins_q.update_n <= (cur_q.cmd != xpc_pkg::XPC_CMD_XWRITE);
        end
        XPC_PULSE: begin
          case (cur_q.cmd)
            xpc_pkg::XPC_CMD_WRITE,
            xpc_pkg::XPC_CMD_XWRITE: pins_q.write_n <= 1'b0;
            xpc_pkg::XPC_CMD_UPDATE: pins_q.update_n <= 1'b0;
            xpc_pkg::XPC_CMD_READ: pins_q.read_n <= 1'b0;
            default: pins_q.reset_n <= 1'b0;
          endcase
        end
        XPC_READ: begin
          pins_q.read_n <= 1'b0; // wait out the access time
        end
        XPC_HOLD: begin
          // strobes rise first; index, data and select hold one more step
          pins_q.write_n <= 1'b1;
          pins_q.read_n <= 1'b1;
          pins_q.update_n <= 1'b1;
          pins_q.reset_n <= 1'b1;
        end
        default: begin
          // bus released only after the device stops driving
          pins_q.select_n <= 1'b1;
          oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // user handshake and readback capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
      reject_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_word_q <= '0;
    end else begin
      ready_q <= (state_q == XPC_IDLE && !(req_valid && ready_q)) || state_q == XPC_DONE;
      reject_q <= (state_q == XPC_IDLE) && req_valid && ready_q && !xpc_legal(req);
      rd_valid_q <= 1'b0;
      if (state_q == XPC_READ && tmr_done) begin
        rd_word_q <= din_sync_q;
        rd_valid_q <= 1'b1;
      end
    end
  end

  assign req_ready = ready_q;
  assign req_reject = reject_q;
  assign rd_valid = rd_valid_q;
  assign rd_word = rd_word_q;
  assign pins = pins_q;
  assign data_out = dout_q;
  assign data_oe_n = oe_n_q;
endmodule
`default_nettype wire

// file: dv/xpc_switch_model.sv
/*
  xpc_switch_model: behavioural crosspoint control latches, two ranks of 17 rows.
  Assumes pins come from the host and bus is the resolved data bus.
*/
`timescale 1ns/1ps
`default_nettype none
module xpc_switch_model (
  // control pins
  input wire xpc_pkg::xpc_pins_t pins,
  // data bus
  input wire logic [6:0] bus,
  output logic [6:0] rd_data,
  output logic rd_oe
);
  logic [6:0] rank1 [17];
  logic [6:0] rank2 [17];
  // level sensitive latches; reset last so it wins over a copy
  always @(pins or bus) begin
    if (!pins.select_n) begin
      // reserved index or an enabled reserved input leaves the rows alone
      if (!pins.write_n && pins.index <= 5'h11
        && (!bus[6] || bus[5:0] <= 6'h20)) begin
        for (int i = 0; i < 17; i++)
          if (pins.index == 5'h11 || pins.index == i[4:0]) rank1[i] = bus;
      end
      if (!pins.update_n) rank2 = rank1;
    end
    if (!pins.reset_n) begin
      for (int i = 0; i < 17; i++) rank2[i][6] = 1'h0;
    end
  end
  // readback; no broadcast row, so that index gives junk
  assign rd_oe = !pins.select_n && !pins.read_n;
  assign rd_data = (pins.index <= 5'h10) ? rank2[pins.index] : 7'h55;
endmodule
`default_nettype wire

// file: dv/xpc_host_checker.sv
/*
  xpc_host_checker: pin sequencing properties of the host.
  Assumes it is bound to xpc_host and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module xpc_host_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // user side
  input wire logic req_reject,
  input wire logic rd_valid,
  // switch side
  input wire xpc_pkg::xpc_pins_t pins,
  input wire logic [xpc_pkg::WORD_W-1:0] data_out,
  input wire logic data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // write strobe held a second step, back high while still selected, then deselect
  sequence s_wr_close;
    !pins.write_n ##1 pins.write_n && !pins.select_n ##1 pins.select_n;
  endsequence
  a_reset_unselected: assert property (!pins.reset_n |-> pins.select_n)
    else $error("reset strobe with select low");
  a_strobe_selected: assert property (
    !(pins.write_n && pins.read_n) |-> !pins.select_n)
    else $error("strobe without select");
  a_data_setup: assert property ($fell(pins.write_n) |-> !data_oe_n
    && $stable(data_out) && $stable(pins.index))
    else $error("data or index not set up before write");
  a_write_close: assert property ($fell(pins.write_n) |=> s_wr_close)
    else $error("write strobe not closed in order");
  a_read_quiet: assert property (!pins.read_n |-> data_oe_n)
    else $error("host drives bus during readback");
  a_reset_width: assert property (
    $fell(pins.reset_n) |=> !pins.reset_n ##1 pins.reset_n)
    else $error("reset pulse width wrong");
  a_reject_idle: assert property (req_reject |-> pins.select_n && $stable(pins))
    else $error("rejected request moved pins");
  a_read_window: assert property (rd_valid |->
    (!pins.read_n && !$past(pins.read_n)) ##1 pins.read_n)
    else $error("read result outside read window");
  a_update_held: assert property ($rose(pins.update_n) |-> !pins.select_n)
    else $error("select dropped before update end");
endmodule
`default_nettype wire

// file: dv/tb_xpc_host.sv
/*
  tb_xpc_host: drives user requests into the host and judges the latch model.
  Assumes xpc_switch_model on the pins and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_xpc_host;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic req_valid = 1'h0;
  xpc_pkg::xpc_req_t req = '0;
  logic req_ready, req_reject, rd_valid, data_oe_n, rd_oe, saw_rej, saw_rd;
  logic [6:0] rd_word, data_out, data_in, rd_data, got;
  xpc_pkg::xpc_pins_t pins;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  // released bus shows the inverse of the last driven value, never a stale copy
  assign data_in = !data_oe_n ? data_out : (rd_oe ? rd_data : ~data_out);
  xpc_host xpc_host_i (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .req_reject(req_reject), .rd_valid(rd_valid), .rd_word(rd_word),
    .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
  xpc_switch_model xpc_switch_model_i (.pins(pins), .bus(data_in), .rd_data(rd_data),
    .rd_oe(rd_oe));
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one request: offered until seen taken, then watched until ready returns
  task automatic do_req(input xpc_pkg::xpc_cmd_t c, input logic [4:0] i, input logic [6:0] w);
    int n;
    n = 0;
    req = '{cmd: c, index: i, word: w};
    req_valid = 1'h1;
    // ready is read settled, one step after the edge that launched it
    while (req_ready !== 1'h1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    // taken at this edge; a refusal pulse stands only in the next cycle
    @(posedge clk);
    #1;
    req_valid = 1'h0;
    saw_rej = (req_reject === 1'h1);
    saw_rd = 1'h0;
    while (req_ready !== 1'h1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
      if (rd_valid === 1'h1) begin
        saw_rd = 1'h1;
        got = rd_word;
      end
    end
    if (n >= 60) chk(7'h00, 7'h01);
  endtask
  // disable, broadcast, single route, transfer, read back
  task automatic t_program();
    do_req(xpc_pkg::XPC_CMD_RESET, 5'h00, 7'h00);
    for (int i = 0; i < 17; i++) chk(7'(xpc_switch_model_i.rank2[i][6]), 7'h00);
    do_req(xpc_pkg::XPC_CMD_WRITE, 5'h11, 7'h47);
    do_req(xpc_pkg::XPC_CMD_WRITE, 5'h10, 7'h60);
    chk(xpc_switch_model_i.rank1[15], 7'h47);
    chk(xpc_switch_model_i.rank1[16], 7'h60);
    chk(7'(xpc_switch_model_i.rank2[16][6]), 7'h00);
    do_req(xpc_pkg::XPC_CMD_UPDATE, 5'h00, 7'h00);
    for (int i = 0; i < 17; i++) chk(xpc_switch_model_i.rank2[i], (i == 16) ? 7'h60 : 7'h47);
    do_req(xpc_pkg::XPC_CMD_READ, 5'h10, 7'h00);
    chk(got, 7'h60);
    chk(7'(saw_rd), 7'h01);
    do_req(xpc_pkg::XPC_CMD_READ, 5'h00, 7'h00);
    chk(got, 7'h47);
  endtask
  // reset clears only live enables; routes and first rank stay
  task automatic t_reset_keeps();
    do_req(xpc_pkg::XPC_CMD_RESET, 5'h00, 7'h00);
    chk(xpc_switch_model_i.rank2[3], 7'h07);
    chk(xpc_switch_model_i.rank1[3], 7'h47);
    do_req(xpc_pkg::XPC_CMD_READ, 5'h03, 7'h00);
    chk(got, 7'h07);
    chk(7'(saw_rd), 7'h01);
  endtask
  // transparent write goes live at once; a disabled route may name any input
  task automatic t_xwrite();
    do_req(xpc_pkg::XPC_CMD_XWRITE, 5'h05, 7'h41);
    chk(xpc_switch_model_i.rank2[5], 7'h41);
    do_req(xpc_pkg::XPC_CMD_WRITE, 5'h06, 7'h3F);
    do_req(xpc_pkg::XPC_CMD_UPDATE, 5'h00, 7'h00);
    chk(xpc_switch_model_i.rank2[6], 7'h3F);
  endtask
  // reserved index, reserved input and broadcast readback are refused
  task automatic t_reject();
    do_req(xpc_pkg::XPC_CMD_WRITE, 5'h12, 7'h41);
    chk(7'(saw_rej), 7'h01);
    do_req(xpc_pkg::XPC_CMD_WRITE, 5'h02, 7'h61);
    chk(7'(saw_rej), 7'h01);
    do_req(xpc_pkg::XPC_CMD_READ, 5'h11, 7'h00);
    chk(7'(saw_rej), 7'h01);
    chk(xpc_switch_model_i.rank1[2], 7'h47);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'h1;
    t_program();
    t_reset_keeps();
    t_xwrite();
    t_reject();
    conclude();
  end
  // hang guard, well above the roughly one hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      conclude();
    end
  end
endmodule
bind xpc_host xpc_host_checker xpc_host_checker_i (.clk(clk), .arst_n(arst_n),
  .req_reject(req_reject), .rd_valid(rd_valid), .pins(pins), .data_out(data_out),
  .data_oe_n(data_oe_n));
`default_nettype wire
